// ===== pps_screen.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
// How it works
// R01: Slot index 0..4, five entries per table
// R02: Prefix recall returns digit count or empty flag
// R03: Blocked entries whole number, wildcard matches any
// R04: Per-port duplex for ports 1..4, reset half
// R05: Value 1 half duplex, 0 full
// R06: Full duplex passes phone audio always
// R07: Half duplex mutes audio while port keyed
// R08: Duplex taken from the port using patch
// R09: Call mode 0 off, 1 ring, 2 control
// R10: Ring mode rings air; control answers line
// R11: Act after programmed ring count, default 1
// R12: Ring mode needs port 1..3, else error 4
// R13: Logon code 1..6 digits, empty gives error 4
// R14: Logon then end digit within 9 seconds
// R15: Control setup renames logon command to code
// R16: Caller ends each command with end digit
// R17: After logon, timeout hangs up by itself
// R18: Air answer only while ringing, no response
// R19: One air ring tone per line ring
module pps_screen #(
    parameter longint LOGON_CYCLES = pps_pkg::LOGON_CYC,
    parameter longint IDLE_CYCLES  = pps_pkg::IDLE_CYC
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Telephone line and patch user
    input  wire pps_pkg::pps_line_t lineIn,
    input  wire logic [1:0]  patchPort,
    input  wire logic [3:0]  pttKeyed,
    output logic             offHook,
    output logic             audioMute,
    output logic [2:0]       airRing,
    output logic             loggedOn,
    output logic             irq
);
    // Elaboration check: a zero count would wrap the 40-bit compare to its maximum and never hang up in practice
    if (LOGON_CYCLES < 1 || IDLE_CYCLES < 1)
    begin : g_badTimeout
        $error("Timeout counts must be positive");
    end

    // Tables and settings
    pps_pkg::pps_slot_t prefixTab [pps_pkg::SLOTS];
    pps_pkg::pps_slot_t blockTab  [pps_pkg::SLOTS];
    logic [3:0]  halfDup_reg;                // One bit per radio port
    logic [1:0]  mode_reg;
    logic [7:0]  ringsNeed_reg;              // Binary ring count
    logic [2:0]  ringPorts_reg;
    logic [23:0] logonCode_reg;              // Logon command name
    logic [2:0]  logonLen_reg;
    logic [31:0] arg0_reg;
    logic [31:0] arg1_reg;
    logic [31:0] resp_reg;
    logic [pps_pkg::IRQ_W-1:0] irqStat_reg;
    logic [pps_pkg::IRQ_W-1:0] irqEn_reg;
    logic [pps_pkg::IRQ_W-1:0] irqSet;
    logic [7:0]  ringCnt_reg;
    logic        ringing_reg;
    logic [39:0] timer_reg;
    logic [23:0] entry_reg;
    logic [2:0]  entryLen_reg;

    typedef enum {ST_IDLE, ST_WAIT_LOGON, ST_ONLINE, ST_PATCH} pps_call_t;
    pps_call_t callSt;

    // Wildcard-aware comparison of a dialled number against a stored one
    function automatic logic numMatch(input pps_pkg::pps_slot_t s, input logic [63:0] n,
                                      input logic [4:0] len);
        logic ok;
        ok = s.used && (s.len == len);
        for (int i = 0; i < pps_pkg::DIGITS; i++)
            if (5'(i) < s.len && s.num[i*4 +: 4] != pps_pkg::DIG_WILD
                && s.num[i*4 +: 4] != n[i*4 +: 4])
                ok = 1'b0;
        return ok;
    endfunction

    // Slot index within range
    function automatic logic slotOk(input logic [2:0] s);
        return s < 3'(pps_pkg::SLOTS);
    endfunction

    // APB decode: zero-wait slave, every access completes in its access phase
    wire        acc  = psel && penable && clkEn;
    wire        wr   = acc && pwrite;
    wire        rd   = acc && !pwrite;
    wire [2:0]  slot = arg0_reg[2:0];
    wire [1:0]  cmdP = arg0_reg[1:0];
    logic       known;
    always_comb
    begin
        unique case (paddr)
            pps_pkg::OFS_CMD, pps_pkg::OFS_ARG0, pps_pkg::OFS_ARG1, pps_pkg::OFS_RESP,
            pps_pkg::OFS_CFG, pps_pkg::OFS_STAT, pps_pkg::OFS_IRQSTAT,
            pps_pkg::OFS_IRQCLR, pps_pkg::OFS_IRQEN, pps_pkg::OFS_LOGON:
                known = 1'b1;
            default:
                known = 1'b0;
        endcase
    end

    // Bus handshake and read data
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    pps_pkg::OFS_ARG0:    prdata <= arg0_reg;
                    pps_pkg::OFS_ARG1:    prdata <= arg1_reg;
                    pps_pkg::OFS_RESP:    prdata <= resp_reg;
                    pps_pkg::OFS_CFG:     prdata <= {12'h000, ringPorts_reg, ringsNeed_reg,
                                                     3'h0, mode_reg, halfDup_reg};
                    pps_pkg::OFS_STAT:    prdata <= {26'h0000000, 1'b0, ringing_reg,
                                                     loggedOn, offHook, audioMute, irq};
                    pps_pkg::OFS_IRQSTAT: prdata <= {28'h0000000, irqStat_reg};
                    pps_pkg::OFS_IRQEN:   prdata <= {28'h0000000, irqEn_reg};
                    pps_pkg::OFS_LOGON:   prdata <= {5'h00, logonLen_reg, logonCode_reg};
                    default:              prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // The access phase is one cycle: pready rises the cycle after setup
    wire doWr  = wr && pready;
    wire doCmd = doWr && paddr == pps_pkg::OFS_CMD;

    // Argument registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            arg0_reg <= 32'h0000_0000;
            arg1_reg <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            if (doWr && paddr == pps_pkg::OFS_ARG0)
                arg0_reg <= pwdata;
            if (doWr && paddr == pps_pkg::OFS_ARG1)
                arg1_reg <= pwdata;
        end
    end

    // Command execution: tables, duplex, call configuration
    logic cmdErr;
    logic cmdDone;
    logic airAnswer;
    logic hangCmd;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < pps_pkg::SLOTS; i++)
            begin
                prefixTab[i] <= '0;
                blockTab[i]  <= '0;
            end
            halfDup_reg   <= 4'hF;                       // [R04]
            mode_reg      <= pps_pkg::MODE_OFF;          // [R09]
            ringsNeed_reg <= pps_pkg::RINGS_DEFAULT;     // [R11]
            ringPorts_reg <= 3'h0;
            logonCode_reg <= 24'h000000;
            logonLen_reg  <= 3'h0;
            resp_reg      <= 32'h0000_0000;
            cmdErr        <= 1'b0;
            cmdDone       <= 1'b0;
            airAnswer     <= 1'b0;
            hangCmd       <= 1'b0;
        end
        else if (clkEn)
        begin
            cmdErr    <= 1'b0;
            cmdDone   <= 1'b0;
            airAnswer <= 1'b0;
            hangCmd   <= 1'b0;
            if (doCmd)
            begin
                cmdDone <= 1'b1;
                unique case (pwdata[3:0])
                    pps_pkg::CMD_SET_PREFIX, pps_pkg::CMD_SET_BLOCKED:
                        if (!slotOk(slot))                       // [R01]
                            cmdErr <= 1'b1;
                        else if (pwdata[3:0] == pps_pkg::CMD_SET_PREFIX)
                            prefixTab[slot] <= '{arg0_reg[8:4] != 5'h00, arg0_reg[8:4],
                                                  {arg1_reg, 32'h0000_0000} >> 32};
                        else
                            blockTab[slot] <= '{arg0_reg[8:4] != 5'h00, arg0_reg[8:4],
                                                {arg1_reg, 32'h0000_0000} >> 32}; // [R03]
                    pps_pkg::CMD_RECALL_PREFIX, pps_pkg::CMD_RECALL_BLOCK:
                        if (!slotOk(slot))
                            cmdErr <= 1'b1;
                        else if (pwdata[3:0] == pps_pkg::CMD_RECALL_PREFIX)
                            // Bit 31 flags an empty slot                [R02]
                            resp_reg <= prefixTab[slot].used ?
                                {3'h0, prefixTab[slot].len, 21'h000000, slot} :
                                {1'b1, 28'h0000000, slot};
                        else
                            resp_reg <= {3'h0, blockTab[slot].len, 21'h000000, slot};
                    pps_pkg::CMD_SET_DUPLEX:
                        halfDup_reg[cmdP] <= arg1_reg[0];        // [R05]
                    pps_pkg::CMD_RECALL_DUPLEX:
                        resp_reg <= {28'h0000000, halfDup_reg};
                    pps_pkg::CMD_CALL_CONFIG:
                        if (arg1_reg[1:0] == pps_pkg::MODE_RING && arg1_reg[12:10] == 3'h0)
                        begin
                            cmdErr   <= 1'b1;                    // [R12]
                            resp_reg <= {28'h0000000, pps_pkg::ERR_CONFIG};
                        end
                        else if (arg1_reg[1:0] == pps_pkg::MODE_CTRL
                                 && (arg1_reg[15:13] == 3'h0
                                     || arg1_reg[15:13] > 3'(pps_pkg::CODE_MAX)))
                        begin
                            cmdErr   <= 1'b1;                    // [R13]
                            resp_reg <= {28'h0000000, pps_pkg::ERR_CONFIG};
                        end
                        else
                        begin
                            mode_reg      <= arg1_reg[1:0];      // [R09]
                            ringsNeed_reg <= arg1_reg[9:2];      // [R11]
                            ringPorts_reg <= arg1_reg[12:10];    // [R12]
                            if (arg1_reg[1:0] == pps_pkg::MODE_CTRL)
                            begin
                                logonCode_reg <= arg0_reg[23:0]; // [R15]
                                logonLen_reg  <= arg1_reg[15:13];
                            end
                            resp_reg <= {28'h0000000, pps_pkg::ERR_NONE};
                        end
                    pps_pkg::CMD_AIR_ANSWER:
                        airAnswer <= 1'b1;                       // [R18]
                    pps_pkg::CMD_HANG_UP:
                        hangCmd <= 1'b1;
                    pps_pkg::CMD_MATCH_BLOCKED:
                    begin
                        resp_reg <= 32'h0000_0000;
                        for (int i = 0; i < pps_pkg::SLOTS; i++)
                            if (numMatch(blockTab[i], {32'h0000_0000, arg1_reg},
                                         arg0_reg[8:4]))
                                resp_reg <= 32'h8000_0000 | 32'(i);  // [R03]
                    end
                    default:
                        cmdErr <= 1'b1;
                endcase
            end
        end
    end

    // Logon entry: digits shift in until the end-of-entry digit [R16]
    wire digitIn = lineIn.digit && clkEn;
    wire eoe     = digitIn && lineIn.code == pps_pkg::DIG_EOE;
    wire codeOk  = eoe && entryLen_reg == logonLen_reg && entry_reg == logonCode_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst || (clkEn && callSt != ST_WAIT_LOGON))
        begin
            entry_reg    <= 24'h000000;
            entryLen_reg <= 3'h0;
        end
        else if (eoe)
        begin
            entry_reg    <= 24'h000000;
            entryLen_reg <= 3'h0;
        end
        else if (digitIn && entryLen_reg < 3'(pps_pkg::CODE_MAX))
        begin
            entry_reg    <= {entry_reg[19:0], lineIn.code};
            entryLen_reg <= entryLen_reg + 3'h1;
        end
    end

    // Incoming call sequencing
    wire ringEv   = lineIn.ring && clkEn;
    wire countHit = ringCnt_reg + 8'h01 >= ringsNeed_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            callSt      <= ST_IDLE;
            ringCnt_reg <= 8'h00;
            ringing_reg <= 1'b0;
            timer_reg   <= 40'h00_0000_0000;
            offHook     <= 1'b0;
            loggedOn    <= 1'b0;
            airRing     <= 3'h0;
        end
        else if (clkEn)
        begin
            airRing <= 3'h0;
            unique case (callSt)
                ST_IDLE:
                begin
                    offHook  <= 1'b0;
                    loggedOn <= 1'b0;
                    if (ringEv && mode_reg != pps_pkg::MODE_OFF)
                    begin
                        ringCnt_reg <= ringCnt_reg + 8'h01;
                        ringing_reg <= 1'b1;
                        if (countHit && mode_reg == pps_pkg::MODE_RING)
                            airRing <= ringPorts_reg;            // [R19] [R10]
                        else if (countHit && mode_reg == pps_pkg::MODE_CTRL)
                        begin
                            offHook   <= 1'b1;                   // [R10]
                            callSt    <= ST_WAIT_LOGON;
                            timer_reg <= 40'h00_0000_0000;
                            ringCnt_reg <= 8'h00;
                        end
                    end
                    if (airAnswer && ringing_reg)
                    begin
                        offHook     <= 1'b1;                     // [R18]
                        callSt      <= ST_PATCH;
                        ringCnt_reg <= 8'h00;
                        ringing_reg <= 1'b0;
                    end
                end
                ST_WAIT_LOGON:
                begin
                    ringing_reg <= 1'b0;
                    timer_reg   <= timer_reg + 40'h00_0000_0001;
                    if (codeOk)
                    begin
                        loggedOn  <= 1'b1;
                        callSt    <= ST_ONLINE;
                        timer_reg <= 40'h00_0000_0000;
                    end
                    else if (hangCmd || timer_reg >= 40'(LOGON_CYCLES - 1))
                    begin
                        offHook <= 1'b0;                         // [R14]
                        callSt  <= ST_IDLE;
                    end
                end
                ST_ONLINE:
                begin
                    timer_reg <= digitIn ? 40'h00_0000_0000 : timer_reg + 40'h00_0000_0001;
                    if (hangCmd || timer_reg >= 40'(IDLE_CYCLES - 1))
                    begin
                        offHook <= 1'b0;                         // [R17]
                        callSt  <= ST_IDLE;
                    end
                end
                ST_PATCH:
                    if (hangCmd)
                    begin
                        offHook <= 1'b0;
                        callSt  <= ST_IDLE;
                    end
            endcase
            // A second call while logged on inherits the logon      [R17]
            if (callSt == ST_ONLINE && ringEv)
                offHook <= 1'b1;
        end
    end

    // Phone audio mute from the patch user's duplex setting
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            audioMute <= 1'b0;
        else if (clkEn)
            audioMute <= halfDup_reg[patchPort] && pttKeyed[patchPort]; // [R06] [R07] [R08]
    end

    // Interrupt status: set wins over clear; hang-up is the fall of the hook
    logic offHookQ;                              // Hook level one cycle back
    assign irqSet = {offHookQ && !offHook, ringEv, cmdErr, cmdDone};
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            irqStat_reg <= '0;
            irqEn_reg   <= '0;
            irq         <= 1'b0;
            offHookQ    <= 1'b0;
        end
        else if (clkEn)
        begin
            irqStat_reg <= (irqStat_reg & ~((doWr && paddr == pps_pkg::OFS_IRQCLR) ?
                           pwdata[pps_pkg::IRQ_W-1:0] : '0)) | irqSet;
            if (doWr && paddr == pps_pkg::OFS_IRQEN)
                irqEn_reg <= pwdata[pps_pkg::IRQ_W-1:0];
            irq <= |(irqStat_reg & irqEn_reg);
            offHookQ <= offHook;
        end
    end

    // Checks
    property p_mute;
        @(posedge clk) disable iff (sys_rst)
        clkEn |=> audioMute == ($past(halfDup_reg[patchPort]) && $past(pttKeyed[patchPort]));
    endproperty
    a_mute: assert property (p_mute) else $error("mute wrong"); // [R07]
    property p_ringcfg;
        @(posedge clk) disable iff (sys_rst)
        doCmd && pwdata[3:0] == pps_pkg::CMD_CALL_CONFIG && arg1_reg[1:0] == pps_pkg::MODE_RING
        && arg1_reg[12:10] == 3'h0 && clkEn |=> cmdErr && $stable(mode_reg);
    endproperty
    a_ringcfg: assert property (p_ringcfg) else $error("ring config accepted"); // [R12]
    property p_resetdup;
        @(posedge clk) sys_rst |=> halfDup_reg == 4'hF && mode_reg == pps_pkg::MODE_OFF;
    endproperty
    a_resetdup: assert property (p_resetdup) else $error("bad defaults"); // [R04]
    property p_airans;
        @(posedge clk) disable iff (sys_rst)
        $rose(offHook) && callSt == ST_PATCH |-> $past(ringing_reg, 1);
    endproperty
    a_airans: assert property (p_airans) else $error("answered without ring"); // [R18]
    property p_logon;
        @(posedge clk) disable iff (sys_rst)
        callSt == ST_WAIT_LOGON && clkEn && codeOk |=> loggedOn;
    endproperty
    a_logon: assert property (p_logon) else $error("logon missed"); // [R14]
    property p_ring;
        @(posedge clk) disable iff (sys_rst)
        |airRing |-> $past(mode_reg) == pps_pkg::MODE_RING;
    endproperty
    a_ring: assert property (p_ring) else $error("air ring in wrong mode"); // [R19]
    property p_ctrl;
        @(posedge clk) disable iff (sys_rst)
        callSt == ST_IDLE && $past(callSt) == ST_IDLE ##1 callSt == ST_WAIT_LOGON |-> offHook;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("answer without off hook"); // [R10]
    property p_slot;
        @(posedge clk) disable iff (sys_rst)
        doCmd && pwdata[3:0] == pps_pkg::CMD_SET_PREFIX && slot > 3'h4 |=> cmdErr;
    endproperty
    a_slot: assert property (p_slot) else $error("bad slot accepted"); // [R01]
endmodule

// ===== pps_pkg.sv
package pps_pkg;
    // Table geometry
    localparam int SLOTS      = 5;
    localparam int DIGITS     = 16;
    localparam int CODE_MAX   = 6;
    localparam int PORTS      = 4;
    // Register byte offsets
    localparam logic [7:0] OFS_CMD     = 8'h00;
    localparam logic [7:0] OFS_ARG0    = 8'h04;
    localparam logic [7:0] OFS_ARG1    = 8'h08;
    localparam logic [7:0] OFS_RESP    = 8'h0C;
    localparam logic [7:0] OFS_CFG     = 8'h10;
    localparam logic [7:0] OFS_STAT    = 8'h14;
    localparam logic [7:0] OFS_IRQSTAT = 8'h18;
    localparam logic [7:0] OFS_IRQCLR  = 8'h1C;
    localparam logic [7:0] OFS_IRQEN   = 8'h20;
    localparam logic [7:0] OFS_LOGON   = 8'h24;
    // Command codes written to the command register
    localparam logic [3:0] CMD_SET_PREFIX    = 4'h0;
    localparam logic [3:0] CMD_RECALL_PREFIX = 4'h1;
    localparam logic [3:0] CMD_SET_BLOCKED   = 4'h2;
    localparam logic [3:0] CMD_RECALL_BLOCK  = 4'h3;
    localparam logic [3:0] CMD_SET_DUPLEX    = 4'h4;
    localparam logic [3:0] CMD_RECALL_DUPLEX = 4'h5;
    localparam logic [3:0] CMD_CALL_CONFIG   = 4'h6;
    localparam logic [3:0] CMD_AIR_ANSWER    = 4'h7;
    localparam logic [3:0] CMD_HANG_UP       = 4'h8;
    localparam logic [3:0] CMD_MATCH_BLOCKED = 4'h9;
    // Incoming-call modes
    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_RING = 2'h1;
    localparam logic [1:0] MODE_CTRL = 2'h2;
    // Digit codes
    localparam logic [3:0] DIG_WILD = 4'hC;
    localparam logic [3:0] DIG_EOE  = 4'hB;
    // Error code for bad configuration
    localparam logic [3:0] ERR_CONFIG = 4'h4;
    localparam logic [3:0] ERR_NONE   = 4'h0;
    // Defaults
    localparam logic [7:0] RINGS_DEFAULT = 8'h01;
    // Timing
    localparam int CLK_HZ         = 100_000_000;
    localparam int LOGON_WAIT_S   = 9;
    localparam longint LOGON_CYC  = longint'(LOGON_WAIT_S) * CLK_HZ;
    localparam int IDLE_TMO_S     = 180;
    localparam longint IDLE_CYC   = longint'(IDLE_TMO_S) * CLK_HZ;
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_RING = 2;
    localparam int IRQ_HANG = 3;
    localparam int IRQ_W    = 4;
    // One table slot: digits packed low digit first, length in digits
    typedef struct packed {
        logic       used;
        logic [4:0] len;
        logic [63:0] num;
    } pps_slot_t;
    // Line-side events
    typedef struct packed {
        logic       ring;
        logic       digit;
        logic [3:0] code;
    } pps_line_t;
endpackage

// ===== pps_line_model.sv
`timescale 1ns/1ps
// Telephone line as seen by the block: ring bursts and keyed digits
module pps_line_model (
    // Clock
    input  wire logic          clk,
    // Line events toward the block
    output pps_pkg::pps_line_t lineOut
);
    // Quiet line at time zero
    initial lineOut = '0;
    // One ring pulse for each ring burst on the line
    task automatic ring();
        @(posedge clk) lineOut.ring <= 1'b1;
        @(posedge clk) lineOut.ring <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // One keyed digit; code is inverted afterwards so a stale value never looks valid
    task automatic dial(input logic [3:0] d);
        @(posedge clk) lineOut <= '{ring: 1'b0, digit: 1'b1, code: d};
        @(posedge clk) lineOut.digit <= 1'b0;
        lineOut.code <= ~d;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, sysRst = 1, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [1:0]  patchPort = '0;
    logic [3:0]  pttKeyed = '0;
    logic [2:0]  airRing;
    logic        offHook, audioMute, loggedOn, irq, errSeen;
    pps_pkg::pps_line_t lineIn;
    int miscompares = 0, n_tests = 0, rings = 0;
    // Duplex rows: set?, port, half bit, patch user, keyed ports, expected mute
    typedef struct packed {logic s; logic [2:0] p; logic h; logic [1:0] u; logic [3:0] k;
        logic m;} pps_row_t;
    pps_row_t rows [6] = '{'{0,0,0,0,4'h1,1}, '{0,0,0,0,4'h0,0}, '{1,0,0,0,4'h1,0},
        '{0,1,0,1,4'h2,1}, '{0,1,0,1,4'h1,0}, '{1,0,1,0,4'h1,1}};
    always #5 clk = ~clk;
    // Ring tones toward port 1, counted as they come
    always @(posedge clk) rings <= rings + int'(airRing[0]);
    pps_screen #(.LOGON_CYCLES(100), .IDLE_CYCLES(200)) i_pps_screen (.clk(clk),
        .sys_rst(sysRst), .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lineIn(lineIn), .patchPort(patchPort), .pttKeyed(pttKeyed), .offHook(offHook),
        .audioMute(audioMute), .airRing(airRing), .loggedOn(loggedOn), .irq(irq));
    pps_line_model i_pps_line_model (.clk(clk), .lineOut(lineIn));
    // Single comparison point
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // APB transfer; waits for pready, bounded only by the watchdog
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        errSeen = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Arguments first, then the command, then the response word
    task automatic cmd(input logic [3:0] c, input logic [31:0] a0, input logic [31:0] a1);
        apb(1, pps_pkg::OFS_ARG0, a0);
        apb(1, pps_pkg::OFS_ARG1, a1);
        apb(1, pps_pkg::OFS_CMD, {28'h0, c});
        apb(0, pps_pkg::OFS_RESP, 32'h0);
    endtask
    // Wait for the hook to reach a level, at most lim cycles
    task automatic hook(input logic v, input int lim);
        for (int n = 0; n < lim && offHook !== v; n++) @(posedge clk);
        chk("offHook", offHook, v);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog sized well past the expected run
    initial
    begin
        #200us;
        miscompares++;
        final_report();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        chk("reset outputs", {offHook, audioMute, loggedOn, irq}, 4'h0);
        // Duplex rows: mute follows the patch user's setting and its key
        foreach (rows[i])
        begin
            if (rows[i].s)
                cmd(pps_pkg::CMD_SET_DUPLEX, {29'h0, rows[i].p}, {31'h0, rows[i].h});
            @(posedge clk) {patchPort, pttKeyed} <= {rows[i].u, rows[i].k};
            repeat (3) @(posedge clk);
            chk("audioMute", audioMute, rows[i].m);
        end
        cmd(pps_pkg::CMD_SET_DUPLEX, 32'h3, 32'h0);
        cmd(pps_pkg::CMD_RECALL_DUPLEX, 32'h0, 32'h0);
        chk("duplex recall", rd, 32'h7);
        $display("duplex rows done");
        // Empty prefix slot at the top index, then stored one
        cmd(pps_pkg::CMD_RECALL_PREFIX, 32'h4, 32'h0);
        chk("empty slot flag", rd[31], 1'b1);
        cmd(pps_pkg::CMD_SET_PREFIX, 32'h34, 32'h0000_0123);
        cmd(pps_pkg::CMD_RECALL_PREFIX, 32'h4, 32'h0);
        chk("stored slot flag", rd[31], 1'b0);
        // Blocked number with a wildcard digit matches a dialled one
        cmd(pps_pkg::CMD_SET_BLOCKED, 32'h42, {24'h0, 8'h5C});
        cmd(pps_pkg::CMD_MATCH_BLOCKED, 32'h40, 32'h0000_0057);
        chk("blocked match", {rd[31], rd[2:0]}, 4'hA);
        // Bad configurations with the error interrupt enabled, then masked
        apb(1, pps_pkg::OFS_IRQEN, 32'h2);
        cmd(pps_pkg::CMD_CALL_CONFIG, 32'h0, 32'h5);
        chk("no ring port", rd, 32'h4);
        chk("irq raised", irq, 1'b1);
        apb(1, pps_pkg::OFS_IRQCLR, 32'h2);
        cmd(pps_pkg::CMD_CALL_CONFIG, 32'h0, 32'h6);
        chk("empty code", rd, 32'h4);
        apb(1, pps_pkg::OFS_IRQEN, 32'h0);
        apb(0, pps_pkg::OFS_IRQSTAT, 32'h0);
        chk("irq masked", {irq, rd[1]}, 2'b01);
        apb(1, pps_pkg::OFS_IRQCLR, 32'h2);
        apb(0, pps_pkg::OFS_IRQSTAT, 32'h0);
        chk("status cleared", rd[1], 1'b0);
        cmd(pps_pkg::CMD_SET_PREFIX, 32'h5, 32'h0);
        apb(0, pps_pkg::OFS_IRQSTAT, 32'h0);
        chk("bad slot", rd[1], 1'b1);
        apb(0, 8'h3C, 32'h0);
        chk("unmapped", errSeen, 1'b1);
        // Air answer with a quiet line stays on hook
        cmd(pps_pkg::CMD_AIR_ANSWER, 32'h0, 32'h0);
        chk("air answer idle", offHook, 1'b0);
        $display("configuration done");
        // Ring mode, two rings counted, port 1 only
        cmd(pps_pkg::CMD_CALL_CONFIG, 32'h0, 32'h409);
        i_pps_line_model.ring();
        chk("first ring silent", rings, 0);
        i_pps_line_model.ring();
        i_pps_line_model.ring();
        chk("tones per ring", rings, 2);
        cmd(pps_pkg::CMD_AIR_ANSWER, 32'h0, 32'h0);
        chk("air answer ringing", offHook, 1'b1);
        cmd(pps_pkg::CMD_HANG_UP, 32'h0, 32'h0);
        chk("hang up", offHook, 1'b0);
        $display("ring mode done");
        // Control mode, code 1 2: answer, logon, idle hang-up
        cmd(pps_pkg::CMD_CALL_CONFIG, 32'h12, 32'h4006);
        chk("config accepted", rd[3:0], pps_pkg::ERR_NONE);
        i_pps_line_model.ring();
        hook(1'b1, 20);
        i_pps_line_model.dial(4'h1);
        i_pps_line_model.dial(4'h2);
        i_pps_line_model.dial(pps_pkg::DIG_EOE);
        chk("logged on", loggedOn, 1'b1);
        hook(1'b0, 260);
        // Answer with no logon: hang up after the logon wait
        i_pps_line_model.ring();
        hook(1'b1, 20);
        hook(1'b0, 130);
        chk("no logon", loggedOn, 1'b0);
        $display("control mode done");
        final_report();
    end
endmodule
